// ---- design/bfl_pkg.sv ----
// Operation
// - Codes 16h and 17h: big-endian block load, primary/secondary, as user.
// - Codes 1Eh and 1Fh: little-endian block load, primary/secondary, as user.
// - Codes F0h and F1h: big-endian block load, primary/secondary, current privilege.
// - Codes F8h and F9h: little-endian block load, primary/secondary, current privilege.
// - Little-endian variants swap bytes inside each 64-bit register; others big-endian.
// - Fetch one aligned 64-byte block into eight consecutive double registers.
// - Lowest-addressed eight bytes land in lowest register, then ascending.
// - Only each 8-byte portion must be atomic, not the whole block.
// - Block loads may ignore total store ordering; ordering is our choice.
// - Non-cacheable targets: strictly ordered or illegal opcode trap.
// - Watch check covers all 64 bytes, or optionally just the first eight.
// - Translation ignores the page side-effect bit for block loads.
// - Illegal opcode trap when destination is not eight-register aligned.
// - Floating-point-off trap when either enable bit is 0 or no unit.
// - Misaligned trap when any low 6 address bits are nonzero.
// - Privilege trap when privilege bit is 0 and identifier bit 7 is 0.
// - Block load told from shared-opcode loads only by identifier value.
// - Flag 0: immediate identifier, reg+reg; flag 1: identifier register, reg+offset.
// - Illegal opcode trap when flag is 0 and bits 12:5 are nonzero.
package bfl_pkg;
  // Instruction fields
  localparam logic [1:0] OP_MEM        = 2'h3;
  localparam logic [5:0] OP3_ALT_DBL   = 6'h33;
  localparam int         OP_HI         = 31;
  localparam int         OP_LO         = 30;
  localparam int         RD_HI         = 29;
  localparam int         RD_LO         = 25;
  localparam int         OP3_HI        = 24;
  localparam int         OP3_LO        = 19;
  localparam int         IMM_FLAG      = 13;
  localparam int         IMM_ASI_HI    = 12;
  localparam int         IMM_ASI_LO    = 5;
  localparam int         SIMM_HI       = 12;
  // Block identifier codes
  localparam logic [7:0] ASI_BLK_USER_PRI    = 8'h16;
  localparam logic [7:0] ASI_BLK_USER_SEC    = 8'h17;
  localparam logic [7:0] ASI_BLK_USER_PRI_LE = 8'h1e;
  localparam logic [7:0] ASI_BLK_USER_SEC_LE = 8'h1f;
  localparam logic [7:0] ASI_BLK_PRI         = 8'hf0;
  localparam logic [7:0] ASI_BLK_SEC         = 8'hf1;
  localparam logic [7:0] ASI_BLK_PRI_LE      = 8'hf8;
  localparam logic [7:0] ASI_BLK_SEC_LE      = 8'hf9;
  localparam int         ASI_PRIV_BIT        = 7;
  localparam int         ASI_LITTLE_BIT      = 3;
  localparam int         ASI_SEC_BIT         = 0;
  // Block geometry
  localparam int         BEATS         = 8;
  localparam int         ALIGN_BITS    = 6;
  localparam int         BEAT_BITS     = 3;
  // Register map and fields
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_WATCH_LO  = 8'h04;
  localparam logic [7:0] OFF_WATCH_HI  = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_COUNT     = 8'h10;
  localparam logic [2:0] CTRL_RESET    = 3'h0;
  localparam int         CTRL_NC_TRAP  = 0;
  localparam int         CTRL_WATCH8   = 1;
  localparam int         CTRL_WATCH_EN = 2;
  typedef enum logic [2:0] {
    BFL_TRAP_NONE, BFL_TRAP_ILLEGAL, BFL_TRAP_FP_OFF,
    BFL_TRAP_MISALIGN, BFL_TRAP_PRIV, BFL_TRAP_WATCH
  } bfl_trap_e;
  typedef enum logic [1:0] {BFL_IDLE, BFL_REQ, BFL_DATA, BFL_DRAIN} bfl_state_e;
endpackage

// ---- design/bfl_block_fp_load.sv ----
// The APB slave port and the register addresses were left to the implementer.
module bfl_block_fp_load #(
  parameter int VA_W = 64
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // Instruction issue
  input  wire logic              issueValid,
  output logic                   issueReady,
  input  wire logic [31:0]       instr,
  input  wire logic [VA_W-1:0]   rs1Val,
  input  wire logic [VA_W-1:0]   rs2Val,
  input  wire logic [7:0]        asiReg,
  input  wire logic              privilegeStateBit,
  input  wire logic              fpEnableStateBit,
  input  wire logic              fpStatusEnableBit,
  input  wire logic              fpuPresent,
  output logic                   notBlockLoad,
  // Memory and translation
  output logic                   memReq,
  input  wire logic              memGnt,
  input  wire logic              memNonCache,
  output logic [VA_W-1:0]        memAddr,
  output logic                   memSecondary,
  output logic                   memAsUser,
  output logic                   memIgnoreSideEffect,
  output logic                   memStrict,
  input  wire logic              memRvalid,
  input  wire logic [63:0]       memRdata,
  // Floating-point register write
  output logic                   fpWen,
  output logic [4:0]             fpWaddr,
  output logic [63:0]            fpWdata,
  // Completion and traps
  output logic                   done,
  output logic                   trapValid,
  output bfl_pkg::bfl_trap_e     trapCause
);

  // Byte reversal inside one 64-bit register
  function automatic logic [63:0] swap64(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++)
    begin
      r[8*b +: 8] = d[8*(7-b) +: 8];
    end
    return r;
  endfunction

  logic                    isMemAlt;
  logic                    immFlag;
  logic [7:0]              asi;
  logic [VA_W-1:0]         ea;
  logic                    isBlock;
  logic                    rdUnaligned;
  logic                    badImmBits;
  logic                    fpOff;
  logic                    misalign;
  logic                    privViol;
  logic                    watchHit;
  bfl_pkg::bfl_trap_e      cause;
  logic [2:0]              ctrl;
  logic [2:0]              next_ctrl;
  logic [63:0]             watchAddr;
  logic [63:0]             next_watchAddr;
  logic [31:0]             loadCount;
  logic [31:0]             next_loadCount;
  bfl_pkg::bfl_trap_e      lastCause;
  bfl_pkg::bfl_trap_e      next_lastCause;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;
  bfl_pkg::bfl_state_e     state;
  bfl_pkg::bfl_state_e     next_state;
  logic [2:0]              beat;
  logic [2:0]              next_beat;
  logic                    little;
  logic                    next_little;
  logic [4:0]              baseReg;
  logic [4:0]              next_baseReg;
  logic [VA_W-1:0]         next_memAddr;
  logic                    next_memSecondary;
  logic                    next_memAsUser;
  logic                    next_memStrict;
  logic                    next_fpWen;
  logic [4:0]              next_fpWaddr;
  logic [63:0]             next_fpWdata;
  logic                    next_done;
  logic                    next_trapValid;
  bfl_pkg::bfl_trap_e      next_trapCause;
  logic                    next_notBlockLoad;
  logic                    apbAccess;
  logic                    take;

  // Decode: shared opcode is split only by identifier value
  always_comb
  begin
    isMemAlt = instr[bfl_pkg::OP_HI:bfl_pkg::OP_LO] == bfl_pkg::OP_MEM
            && instr[bfl_pkg::OP3_HI:bfl_pkg::OP3_LO] == bfl_pkg::OP3_ALT_DBL;
    immFlag  = instr[bfl_pkg::IMM_FLAG];
    asi      = immFlag ? asiReg : instr[bfl_pkg::IMM_ASI_HI:bfl_pkg::IMM_ASI_LO];
    ea       = immFlag ? rs1Val + {{(VA_W-bfl_pkg::SIMM_HI-1){instr[bfl_pkg::SIMM_HI]}},
                                   instr[bfl_pkg::SIMM_HI:0]}
                       : rs1Val + rs2Val;
    case (asi)
      bfl_pkg::ASI_BLK_USER_PRI, bfl_pkg::ASI_BLK_USER_SEC: isBlock = isMemAlt;
      bfl_pkg::ASI_BLK_USER_PRI_LE, bfl_pkg::ASI_BLK_USER_SEC_LE: isBlock = isMemAlt;
      bfl_pkg::ASI_BLK_PRI, bfl_pkg::ASI_BLK_SEC: isBlock = isMemAlt;
      bfl_pkg::ASI_BLK_PRI_LE, bfl_pkg::ASI_BLK_SEC_LE: isBlock = isMemAlt;
      default: isBlock = 1'b0;
    endcase
    // Encoded rd: double index is {rd[0], rd[4:1]}, so alignment needs rd[3:1] zero
    rdUnaligned = instr[bfl_pkg::RD_LO+3:bfl_pkg::RD_LO+1] != '0;
    badImmBits  = !immFlag && instr[bfl_pkg::IMM_ASI_HI:bfl_pkg::IMM_ASI_LO] != '0;
    fpOff       = !fpEnableStateBit || !fpStatusEnableBit || !fpuPresent;
    misalign    = ea[bfl_pkg::ALIGN_BITS-1:0] != '0;
    privViol    = !privilegeStateBit && !asi[bfl_pkg::ASI_PRIV_BIT];
    // Whole block compare is the preferred check; narrow mode looks at the first beat
    if (ctrl[bfl_pkg::CTRL_WATCH8])
      watchHit = ea[VA_W-1:bfl_pkg::BEAT_BITS] == watchAddr[VA_W-1:bfl_pkg::BEAT_BITS];
    else
      watchHit = ea[VA_W-1:bfl_pkg::ALIGN_BITS] == watchAddr[VA_W-1:bfl_pkg::ALIGN_BITS];
    watchHit = watchHit && ctrl[bfl_pkg::CTRL_WATCH_EN];
    // Priority: illegal, fp off, alignment, privilege, watch
    if (rdUnaligned || badImmBits)
      cause = bfl_pkg::BFL_TRAP_ILLEGAL;
    else if (fpOff)
      cause = bfl_pkg::BFL_TRAP_FP_OFF;
    else if (misalign)
      cause = bfl_pkg::BFL_TRAP_MISALIGN;
    else if (privViol)
      cause = bfl_pkg::BFL_TRAP_PRIV;
    else if (watchHit)
      cause = bfl_pkg::BFL_TRAP_WATCH;
    else
      cause = bfl_pkg::BFL_TRAP_NONE;
  end

  assign issueReady          = state == bfl_pkg::BFL_IDLE;
  assign take                = issueValid && issueReady;
  assign memReq              = state == bfl_pkg::BFL_REQ;
  assign memIgnoreSideEffect = 1'b1;
  assign pready              = 1'b1;
  assign apbAccess           = psel && penable;

  // Sequencer: one block at a time, eight independent 8-byte beats
  always_comb
  begin
    next_state        = state;
    next_beat         = beat;
    next_little       = little;
    next_baseReg      = baseReg;
    next_memAddr      = memAddr;
    next_memSecondary = memSecondary;
    next_memAsUser    = memAsUser;
    next_memStrict    = memStrict;
    next_fpWen        = 1'b0;
    next_fpWaddr      = fpWaddr;
    next_fpWdata      = fpWdata;
    next_done         = 1'b0;
    next_trapValid    = 1'b0;
    next_trapCause    = trapCause;
    next_notBlockLoad = 1'b0;
    next_lastCause    = lastCause;
    next_loadCount    = loadCount;
    case (state)
      bfl_pkg::BFL_IDLE:
      begin
        if (take && !isBlock)
          next_notBlockLoad = 1'b1;
        else if (take && cause != bfl_pkg::BFL_TRAP_NONE)
        begin
          // No request leaves and no register changes
          next_trapValid = 1'b1;
          next_trapCause = cause;
          next_lastCause = cause;
        end
        else if (take)
        begin
          next_state        = bfl_pkg::BFL_REQ;
          next_beat         = '0;
          next_memAddr      = ea;
          next_little       = asi[bfl_pkg::ASI_LITTLE_BIT];
          next_memSecondary = asi[bfl_pkg::ASI_SEC_BIT];
          next_memAsUser    = !asi[bfl_pkg::ASI_PRIV_BIT];
          next_baseReg      = {instr[bfl_pkg::RD_LO], instr[bfl_pkg::RD_HI:bfl_pkg::RD_LO+1]};
          // Strict ordering unless software asks for trapping instead of ordering
          next_memStrict    = !ctrl[bfl_pkg::CTRL_NC_TRAP];
        end
      end
      bfl_pkg::BFL_REQ:
      begin
        if (memGnt && memNonCache && ctrl[bfl_pkg::CTRL_NC_TRAP])
        begin
          // Beats still arrive; they are drained and dropped
          next_state     = bfl_pkg::BFL_DRAIN;
          next_trapValid = 1'b1;
          next_trapCause = bfl_pkg::BFL_TRAP_ILLEGAL;
          next_lastCause = bfl_pkg::BFL_TRAP_ILLEGAL;
        end
        else if (memGnt)
          next_state = bfl_pkg::BFL_DATA;
      end
      bfl_pkg::BFL_DATA, bfl_pkg::BFL_DRAIN:
      begin
        if (memRvalid)
        begin
          // Each beat is written whole, which is all the atomicity owed
          next_fpWen   = state == bfl_pkg::BFL_DATA;
          next_fpWaddr = baseReg + {2'h0, beat};
          next_fpWdata = little ? swap64(memRdata) : memRdata;
          next_beat    = beat + 3'h1;
          if (beat == 3'(bfl_pkg::BEATS - 1))
          begin
            next_state = bfl_pkg::BFL_IDLE;
            next_done  = state == bfl_pkg::BFL_DATA;
            if (state == bfl_pkg::BFL_DATA)
            begin
              next_loadCount = loadCount + 32'h1;
              next_lastCause = bfl_pkg::BFL_TRAP_NONE;
            end
          end
        end
      end
      default: next_state = bfl_pkg::BFL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state        <= bfl_pkg::BFL_IDLE;
      beat         <= '0;
      little       <= 1'b0;
      baseReg      <= '0;
      memAddr      <= '0;
      memSecondary <= 1'b0;
      memAsUser    <= 1'b0;
      memStrict    <= 1'b1;
      fpWen        <= 1'b0;
      fpWaddr      <= '0;
      fpWdata      <= '0;
      done         <= 1'b0;
      trapValid    <= 1'b0;
      trapCause    <= bfl_pkg::BFL_TRAP_NONE;
      notBlockLoad <= 1'b0;
      lastCause    <= bfl_pkg::BFL_TRAP_NONE;
      loadCount    <= '0;
    end
    else
    begin
      state        <= next_state;
      beat         <= next_beat;
      little       <= next_little;
      baseReg      <= next_baseReg;
      memAddr      <= next_memAddr;
      memSecondary <= next_memSecondary;
      memAsUser    <= next_memAsUser;
      memStrict    <= next_memStrict;
      fpWen        <= next_fpWen;
      fpWaddr      <= next_fpWaddr;
      fpWdata      <= next_fpWdata;
      done         <= next_done;
      trapValid    <= next_trapValid;
      trapCause    <= next_trapCause;
      notBlockLoad <= next_notBlockLoad;
      lastCause    <= next_lastCause;
      loadCount    <= next_loadCount;
    end
  end

  // APB registers; read data registered from the setup cycle, zero wait states
  always_comb
  begin
    next_ctrl      = ctrl;
    next_watchAddr = watchAddr;
    next_prdata    = prdata;
    next_pslverr   = 1'b0;
    if (psel && !penable)
    begin
      next_prdata = '0;
      case (paddr)
        bfl_pkg::OFF_CTRL:     next_prdata = {29'h0, ctrl};
        bfl_pkg::OFF_WATCH_LO: next_prdata = watchAddr[31:0];
        bfl_pkg::OFF_WATCH_HI: next_prdata = watchAddr[63:32];
        bfl_pkg::OFF_STATUS:   next_prdata = {28'h0, lastCause, !issueReady};
        bfl_pkg::OFF_COUNT:    next_prdata = loadCount;
        default:               next_pslverr = 1'b1;
      endcase
    end
    if (apbAccess)
      next_pslverr = pslverr;
    if (apbAccess && pwrite)
    begin
      case (paddr)
        bfl_pkg::OFF_CTRL:     next_ctrl = pwdata[2:0];
        bfl_pkg::OFF_WATCH_LO: next_watchAddr[31:0] = pwdata;
        bfl_pkg::OFF_WATCH_HI: next_watchAddr[63:32] = pwdata;
        default:               next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl      <= bfl_pkg::CTRL_RESET;
      watchAddr <= '0;
      prdata    <= '0;
      pslverr   <= 1'b0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      watchAddr <= next_watchAddr;
      prdata    <= next_prdata;
      pslverr   <= next_pslverr;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // A trapped block load never reaches memory in the next cycle
  trap_no_req_a: assert property ((take && isBlock && cause != bfl_pkg::BFL_TRAP_NONE)
    |=> !memReq && trapValid) else $error("trap issued request");
  misalign_trap_a: assert property ((take && isBlock && !rdUnaligned && !badImmBits && !fpOff
    && misalign) |=> trapCause == bfl_pkg::BFL_TRAP_MISALIGN) else $error("misalign");
  priv_trap_a: assert property ((take && isBlock && cause == bfl_pkg::BFL_TRAP_NONE)
    |-> privilegeStateBit || asi[bfl_pkg::ASI_PRIV_BIT]) else $error("priv missed");
  fp_off_a: assert property ((take && isBlock && !rdUnaligned && !badImmBits && !fpuPresent)
    |=> trapCause == bfl_pkg::BFL_TRAP_FP_OFF) else $error("fp off missed");
  rd_align_a: assert property ((take && isBlock && rdUnaligned)
    |=> trapValid && trapCause == bfl_pkg::BFL_TRAP_ILLEGAL) else $error("rd align");
  beat_order_a: assert property ((fpWen && !done) |=> !fpWen || fpWaddr == $past(fpWaddr)
    + 5'h1) else $error("beat order");
  swap_le_a: assert property ((state == bfl_pkg::BFL_DATA && memRvalid && little)
    |=> fpWdata == swap64($past(memRdata))) else $error("swap");
  drain_silent_a: assert property ((state == bfl_pkg::BFL_DRAIN) |=> !fpWen && !done)
    else $error("drain wrote");
  user_priv_a: assert property ((take && isBlock && cause == bfl_pkg::BFL_TRAP_NONE
    && asi[7:4] == 4'h1) |=> memReq && memAsUser) else $error("user space");
  other_load_a: assert property ((take && !isBlock) |=> notBlockLoad && !memReq)
    else $error("shared opcode");
  le_block_c: cover property (take && isBlock && asi[bfl_pkg::ASI_LITTLE_BIT]
    ##[1:40] done);
  nc_trap_c: cover property (memGnt && memNonCache && memReq ##1 trapValid);
  misalign_c: cover property (trapValid && trapCause == bfl_pkg::BFL_TRAP_MISALIGN);
endmodule

// ---- bench/bfl_mem_model.sv ----
module bfl_mem_model (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        memReq,
  input  wire logic [63:0] memAddr,
  input  wire logic        slow,
  input  wire logic        nonCache,
  output logic             memGnt,
  output logic             memNonCache,
  output logic             memRvalid,
  output logic [63:0]      memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] base;
  int          beat;
  int          gap;
  // One grant per request, then eight beats; slow mode leaves gaps between beats
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      {memGnt, memNonCache, memRvalid} <= 3'h0;
      memRdata <= 64'h0;
      base <= 64'h0;
      beat <= -1;
      gap <= 0;
    end
    else
    begin
      memGnt <= 1'b0;
      memRvalid <= 1'b0;
      // Idle lines toggle so that a stale beat can never pass for a fresh one
      memRdata <= ~memRdata;
      memNonCache <= ~memNonCache;
      if (gap > 0)
        gap <= gap - 1;
      else if (beat < 0 && memReq && !memGnt)
      begin
        memGnt <= 1'b1;
        memNonCache <= nonCache;
        base <= memAddr;
        beat <= 0;
        gap <= slow ? 3 : 0;
      end
      else if (beat >= 0)
      begin
        memRvalid <= 1'b1;
        memRdata <= {base[31:0] + (32'(beat) << 3), base[31:0] ^ 32'h5a3c96e1};
        beat <= (beat == 7) ? -1 : beat + 1;
        gap <= slow ? 2 : 0;
      end
    end
  end
endmodule

// ---- bench/block_fp_load_unit_test.sv ----
module block_fp_load_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] kind; logic [4:0] addr; logic [63:0] data;} bfl_exp_s;
  localparam logic [5:0] OP3 = bfl_pkg::OP3_ALT_DBL;
  localparam bfl_pkg::bfl_trap_e TN = bfl_pkg::BFL_TRAP_NONE;
  localparam bfl_pkg::bfl_trap_e TI = bfl_pkg::BFL_TRAP_ILLEGAL;
  localparam logic [7:0] BLK_ASI [8] = '{8'h16, 8'h17, 8'h1e, 8'h1f, 8'hf0, 8'hf1, 8'hf8, 8'hf9};
  localparam logic [4:0] RD_TAB [4] = '{5'h00, 5'h10, 5'h01, 5'h11};
  logic               mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr, asiReg;
  logic [31:0]        pwdata, prdata, instr, seed;
  logic               issueValid, issueReady, privilegeStateBit, fpEnableStateBit;
  logic               fpStatusEnableBit, fpuPresent, notBlockLoad, memReq, memGnt;
  logic               memNonCache, memSecondary, memAsUser, memIgnoreSideEffect, memStrict;
  logic               memRvalid, fpWen, done, trapValid, slow, nonCache, ncTrap;
  logic [63:0]        rs1Val, rs2Val, memAddr, memRdata, fpWdata;
  logic [4:0]         fpWaddr;
  bfl_pkg::bfl_trap_e trapCause;
  bfl_exp_s           expQ[$];
  bfl_exp_s           e;
  int                 errors, n_compared, nLoads, nDone, nBeats;

  bfl_block_fp_load bfl_block_fp_load_inst (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .issueValid, .issueReady, .instr, .rs1Val, .rs2Val,
    .asiReg, .privilegeStateBit, .fpEnableStateBit, .fpStatusEnableBit, .fpuPresent,
    .notBlockLoad, .memReq, .memGnt, .memNonCache, .memAddr, .memSecondary, .memAsUser,
    .memIgnoreSideEffect, .memStrict, .memRvalid, .memRdata, .fpWen, .fpWaddr, .fpWdata,
    .done, .trapValid, .trapCause);
  bfl_mem_model bfl_mem_model_inst (.mclk, .nrst, .memReq, .memAddr, .slow, .nonCache,
    .memGnt, .memNonCache, .memRvalid, .memRdata);

  // Free-running core clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [63:0] swap8(input logic [63:0] d);
    logic [63:0] r;
    for (int b = 0; b < 8; b++)
      r[8*b +: 8] = d[56-8*b +: 8];
    return r;
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; d is write data or expected read data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    if (!wr)
      chk("prdata", 64'(d), 64'(prdata));
    chk("pslverr", 64'(err), 64'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Issue one instruction; ctl is {priv, fpu present, status enable, state enable}
  task automatic issue(input logic [4:0] rd, input logic [5:0] op3, input logic [7:0] asi,
                       input logic [63:0] rs1, input logic [12:0] off, input logic [3:0] ctl,
                       input bfl_pkg::bfl_trap_e cause, input logic req, input logic nb);
    logic [63:0] ea;
    logic [63:0] d;
    int          tgt;
    ea = rs1 + {{51{off[12]}}, off};
    seed = lfsr(seed);
    if (nb)
      expQ.push_back('{2'h2, 5'h0, 64'h0});
    else if (cause != TN)
      expQ.push_back('{2'h1, 5'h0, 64'(cause)});
    else
      for (int k = 0; k < 8; k++)
      begin
        d = {ea[31:0] + 32'(k * 8), ea[31:0] ^ 32'h5a3c96e1};
        expQ.push_back('{2'h0, 5'({rd[0], rd[4:1]} + k), asi[3] ? swap8(d) : d});
      end
    {privilegeStateBit, fpuPresent, fpStatusEnableBit, fpEnableStateBit} <= ctl;
    instr <= {2'h3, rd, op3, 5'h01, 1'b1, off};
    rs1Val <= rs1;
    rs2Val <= 64'(seed);
    asiReg <= asi;
    issueValid <= 1'b1;
    do @(posedge mclk); while (issueReady !== 1'b1);
    issueValid <= 1'b0;
    #1;
    chk("memReq", 64'(req), 64'(memReq));
    if (req)
    begin
      chk("memAddr", ea, memAddr);
      chk("memAttr", {asi[0], ~asi[7], 1'b1, ~ncTrap, 1'b0}, {memSecondary,
          memAsUser, memIgnoreSideEffect, memStrict, issueReady});
      tgt = nBeats + 8;
      for (int i = 0; i < 300 && nBeats < tgt; i++)
        @(posedge mclk);
      repeat (2) @(posedge mclk);
      if (cause == TN)
        nLoads++;
    end
  endtask

  // Result watcher: every write, trap or not-block pulse takes the oldest expectation off the queue
  always @(posedge mclk)
  begin
    if (memRvalid === 1'b1)
      nBeats++;
    if (done === 1'b1)
      nDone++;
    if (fpWen === 1'b1 || trapValid === 1'b1 || notBlockLoad === 1'b1)
    begin
      if (expQ.size() == 0)
        chk("unexpected", 64'h0, 64'h1);
      else
      begin
        e = expQ.pop_front();
        chk("kind", 64'(e.kind), fpWen === 1'b1 ? 64'h0 : trapValid === 1'b1 ? 64'h1 : 64'h2);
        if (e.kind == 2'h0)
          chk("fpWaddr", 64'(e.addr), 64'(fpWaddr));
        if (e.kind == 2'h0)
          chk("fpWdata", e.data, fpWdata);
        if (e.kind == 2'h1)
          chk("trapCause", e.data, 64'(trapCause));
      end
    end
  end

  // Watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge mclk);
    chk("watchdog", 64'h0, 64'h1);
    stop_test;
  end

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, issueValid, slow, nonCache, ncTrap} = 7'h0;
    {paddr, asiReg, pwdata, instr, rs1Val, rs2Val} = 208'h0;
    {privilegeStateBit, fpuPresent, fpStatusEnableBit, fpEnableStateBit} = 4'hf;
    seed = 32'h000113ed;
    nrst = 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    apb(1'b0, bfl_pkg::OFF_CTRL, 32'h0, 1'b0);
    apb(1'b1, 8'h14, 32'h7, 1'b1);
    apb(1'b0, 8'h14, 32'h0, 1'b1);
    $display("test registers done");
    for (int j = 0; j < 8; j++)
    begin
      seed = lfsr(seed);
      slow <= seed[7];
      issue(RD_TAB[j % 4], OP3, BLK_ASI[j], {32'h0, seed[25:0], 6'h0} + 64'h40,
            j[0] ? 13'h1fc0 : 13'h0, 4'hf, TN, 1'b1, 1'b0);
    end
    $display("test block loads done");
    issue(5'h00, OP3, 8'hf0, 64'h1000, 13'h0, 4'h7, TN, 1'b1, 1'b0);
    issue(5'h00, OP3, 8'h1e, 64'h1000, 13'h0, 4'h7, bfl_pkg::BFL_TRAP_PRIV, 1'b0, 1'b0);
    issue(5'h02, OP3, 8'hf0, 64'h1000, 13'h0, 4'hf, TI, 1'b0, 1'b0);
    issue(5'h04, OP3, 8'hf0, 64'h1000, 13'h20, 4'hf, TI, 1'b0, 1'b0);
    issue(5'h00, OP3, 8'hf0, 64'h1000, 13'h0, 4'hb, bfl_pkg::BFL_TRAP_FP_OFF, 1'b0, 1'b0);
    issue(5'h00, OP3, 8'hf0, 64'h1000, 13'h0, 4'he, bfl_pkg::BFL_TRAP_FP_OFF, 1'b0, 1'b0);
    issue(5'h00, OP3, 8'hf0, 64'h1000, 13'h0, 4'hd, bfl_pkg::BFL_TRAP_FP_OFF, 1'b0, 1'b0);
    issue(5'h00, OP3, 8'hf0, 64'h1000, 13'h8, 4'hf, bfl_pkg::BFL_TRAP_MISALIGN, 1'b0, 1'b0);
    issue(5'h00, OP3, 8'h80, 64'h1000, 13'h0, 4'hf, TN, 1'b0, 1'b1);
    issue(5'h00, 6'h23, 8'hf0, 64'h1000, 13'h0, 4'hf, TN, 1'b0, 1'b1);
    $display("test traps done");
    apb(1'b1, bfl_pkg::OFF_CTRL, 32'h1, 1'b0);
    ncTrap = 1'b1;
    nonCache <= 1'b1;
    issue(5'h10, OP3, 8'hf8, 64'h3000, 13'h0, 4'hf, TI, 1'b1, 1'b0);
    apb(1'b1, bfl_pkg::OFF_CTRL, 32'h0, 1'b0);
    ncTrap = 1'b0;
    issue(5'h10, OP3, 8'hf8, 64'h3000, 13'h0, 4'hf, TN, 1'b1, 1'b0);
    nonCache <= 1'b0;
    $display("test non-cacheable done");
    apb(1'b1, bfl_pkg::OFF_WATCH_LO, 32'h00002008, 1'b0);
    apb(1'b1, bfl_pkg::OFF_WATCH_HI, 32'h0, 1'b0);
    apb(1'b1, bfl_pkg::OFF_CTRL, 32'h4, 1'b0);
    issue(5'h00, OP3, 8'hf0, 64'h2000, 13'h0, 4'hf, bfl_pkg::BFL_TRAP_WATCH, 1'b0, 1'b0);
    apb(1'b1, bfl_pkg::OFF_CTRL, 32'h6, 1'b0);
    issue(5'h00, OP3, 8'hf0, 64'h2000, 13'h0, 4'hf, TN, 1'b1, 1'b0);
    apb(1'b0, bfl_pkg::OFF_COUNT, 32'(nLoads), 1'b0);
    $display("test watch done");
    chk("doneCount", 64'(nLoads), 64'(nDone));
    stop_test;
  end
endmodule
